// ===== core/ilb_link_bonding_regs.sv
// ilb_link_bonding_regs: command, sync, skew and frame loss registers
`timescale 1ns/1ps

// Operation
// R1 - link-start command signals the distant end
// R2 - search for three consecutive sequence numbers
// R3 - no-operation code does nothing
// R4 - other command codes are ignored
// R5 - software writes link-start, then may no-op
// R6 - far sync bits follow peer receive sync
// R7 - local sync bits follow local receiver sync
// R8 - latched copy of each sync bit
// R9 - sync enables gate latched sync bits
// R10 - 8-bit differential delay measure, 64 ms
// R11 - latch skew error above 7.75 ms
// R12 - skew error enable gates latched error
// R13 - frame loss enables gate latched bits
// R14 - frame loss latched on far/local loss
// R15 - software stops sending, repeats link start
// R16 - participation bits select bonded links
// R17 - global status shows any enabled event
// R18 - latched bits hold until software clears
// R19 - latched and enable registers reset zero
module ilb_link_bonding_regs (
    input  wire logic        sys_clk,        // system clock, 250 MHz
    input  wire logic        rst_b,          // sync reset, active low
    // register port
    input  wire logic [7:0]  regAddr,        // register offset
    input  wire logic [7:0]  regWrData,      // write data
    input  wire logic        regWrStb,       // write strobe
    input  wire logic        regRdStb,       // read strobe
    output logic      [7:0]  regRdData,      // read data, cycle after strobe
    // peer side
    output logic             linkStartTx,    // pulse: send link-start to peer
    input  wire logic        peerLinkStart,  // pulse: link-start from peer
    input  wire logic [3:0]  peerRxSync,     // peer reports receive sync
    input  wire logic [3:0]  farFrameLoss,   // distant end out of frame
    input  wire logic [3:0]  localFrameLoss, // local receiver out of frame
    input  wire logic [3:0]  seqValid,       // sequence number strobe per portion
    input  wire logic [31:0] seqNum,         // sequence numbers, 8 bits a portion
    input  wire logic [7:0]  skewMeasure,    // measured delay, 0.25 ms steps
    // datapath control
    output logic      [3:0]  linkParticipate,// links taking part in bonding
    output logic             sendEnable,     // transmit enable
    output logic      [3:0]  linkTxEnable,   // per-link bonded traffic gate
    output logic             bondGlobalIrq   // any enabled event present
);
    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic wrConfig;
    logic wrCommand;
    logic wrSyncIe;
    logic wrSyncLs;
    logic wrSkewIe;
    logic wrSkewLs;
    logic wrFlIe;
    logic wrFlLs;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wrConfig  = regWrStb && hit(regAddr, ilb_pkg::OFF_BOND_CONFIG);
    assign wrCommand = regWrStb && hit(regAddr, ilb_pkg::OFF_BOND_COMMAND);
    assign wrSyncIe  = regWrStb && hit(regAddr, ilb_pkg::OFF_SYNC_IRQ_EN);
    assign wrSyncLs  = regWrStb && hit(regAddr, ilb_pkg::OFF_SYNC_LATCHED);
    assign wrSkewIe  = regWrStb && hit(regAddr, ilb_pkg::OFF_SKEW_ERR_IRQ_EN);
    assign wrSkewLs  = regWrStb && hit(regAddr, ilb_pkg::OFF_SKEW_ERR_LATCHED);
    assign wrFlIe    = regWrStb && hit(regAddr, ilb_pkg::OFF_FRAME_LOSS_IRQ_EN);
    assign wrFlLs    = regWrStb && hit(regAddr, ilb_pkg::OFF_FRAME_LOSS_LATCHED);

    // ------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------
    logic isLinkStart;
    logic linkStart_reg;
    logic [7:0] command_reg;

    // only the start code acts; no-op and any other value do nothing
    assign isLinkStart = wrCommand && (regWrData == ilb_pkg::CMD_LINK_START); // see R1 see R4

    // command byte reads back as last accepted code, all ones after reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            command_reg   <= ilb_pkg::CMD_RESET;
            linkStart_reg <= 1'b0;
        end else begin
            linkStart_reg <= isLinkStart; // see R1
            if (wrCommand && (regWrData == ilb_pkg::CMD_LINK_START ||
                              regWrData == ilb_pkg::CMD_NOP)) begin
                command_reg <= regWrData; // see R3 see R4
            end
        end
    end

    assign linkStartTx = linkStart_reg; // see R1

    // ------------------------------------------------------------
    // configuration and enables
    // ------------------------------------------------------------
    logic [7:0] config_reg;
    logic [7:0] syncIe_reg;
    logic [7:0] skewIe_reg;
    logic [7:0] flIe_reg;

    // enables reset to zero so no event reaches the global status
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            config_reg <= ilb_pkg::RST_CONFIG;
            syncIe_reg <= ilb_pkg::RST_ZERO; // see R19
            skewIe_reg <= ilb_pkg::RST_ZERO; // see R19
            flIe_reg   <= ilb_pkg::RST_ZERO; // see R19
        end else begin
            if (wrConfig) begin
                config_reg <= regWrData & 8'h1F;
            end
            if (wrSyncIe) begin
                syncIe_reg <= regWrData;
            end
            if (wrSkewIe) begin
                skewIe_reg <= regWrData & 8'h01;
            end
            if (wrFlIe) begin
                flIe_reg <= regWrData;
            end
        end
    end

    // a link not participating carries nothing, even with send enabled
    assign linkParticipate = config_reg[ilb_pkg::FLD_PART_LSB +: 4];
    assign sendEnable      = config_reg[ilb_pkg::FLD_SEND_ENABLE]; // see R15
    assign linkTxEnable    = linkParticipate & {4{sendEnable}}; // see R16

    // ------------------------------------------------------------
    // local sequence search, one per portion
    // ------------------------------------------------------------
    logic [3:0] localSync;

    // a local link-start also rearms so both ends search together
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_search
            ilb_seq_search u_search (
                .sys_clk   (sys_clk),
                .rst_b     (rst_b),
                .arm       ((peerLinkStart || isLinkStart) && linkParticipate[gi]), // see R2
                .seqValid  (seqValid[gi]),
                .seqNum    (seqNum[gi*8 +: 8]),
                .frameLoss (localFrameLoss[gi]),
                .inSync    (localSync[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // live and latched status
    // ------------------------------------------------------------
    logic [7:0] syncLive;
    logic [7:0] syncLatched;
    logic [7:0] flLatched;
    logic [7:0] skewLatched;
    logic [7:0] skew_reg;
    logic       skewOver;

    // far sync in the high nibble, local sync in the low nibble
    assign syncLive = {peerRxSync, localSync}; // see R6 see R7

    // delay counts above the 7.75 ms limit raise the error
    assign skewOver = (skew_reg > ilb_pkg::SKEW_LIMIT_CNT); // see R11

    // measure is registered; full scale 255 counts covers 63.75 ms
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            skew_reg <= ilb_pkg::RST_ZERO;
        end else begin
            skew_reg <= skewMeasure; // see R10
        end
    end

    // latched bits: write one to clear, set wins over clear
    ilb_sticky_bits u_sync_ls (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .setEvent (syncLive), // see R8
        .clrMask  (wrSyncLs ? regWrData : 8'h00),
        .latched  (syncLatched)
    );

    ilb_sticky_bits u_fl_ls (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .setEvent ({farFrameLoss, localFrameLoss}), // see R14
        .clrMask  (wrFlLs ? regWrData : 8'h00),
        .latched  (flLatched)
    );

    ilb_sticky_bits u_skew_ls (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .setEvent ({7'h00, skewOver}), // see R11
        .clrMask  (wrSkewLs ? regWrData : 8'h00),
        .latched  (skewLatched)
    );

    // ------------------------------------------------------------
    // global status
    // ------------------------------------------------------------
    logic syncEvt;
    logic skewEvt;
    logic flEvt;
    logic globalIrq_reg;

    assign syncEvt = |(syncLatched & syncIe_reg); // see R9
    assign skewEvt = skewLatched[ilb_pkg::FLD_SKEW_ERR] & skewIe_reg[ilb_pkg::FLD_SKEW_ERR]; // see R12
    assign flEvt   = |(flLatched & flIe_reg); // see R13

    // registered so the output is clean of decode glitches
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            globalIrq_reg <= 1'b0;
        end else begin
            globalIrq_reg <= syncEvt | skewEvt | flEvt; // see R17
        end
    end

    assign bondGlobalIrq = globalIrq_reg;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rdMux;
    logic [7:0] rdData_reg;

    // unmapped offsets read as zero
    always_comb begin
        unique case (regAddr)
            ilb_pkg::OFF_BOND_CONFIG:        rdMux = config_reg;
            ilb_pkg::OFF_BOND_COMMAND:       rdMux = command_reg;
            ilb_pkg::OFF_SYNC_LIVE:          rdMux = syncLive;
            ilb_pkg::OFF_SYNC_IRQ_EN:        rdMux = syncIe_reg;
            ilb_pkg::OFF_SYNC_LATCHED:       rdMux = syncLatched;
            ilb_pkg::OFF_SKEW_MEASURE:       rdMux = skew_reg;
            ilb_pkg::OFF_SKEW_ERR_IRQ_EN:    rdMux = skewIe_reg;
            ilb_pkg::OFF_SKEW_ERR_LATCHED:   rdMux = skewLatched;
            ilb_pkg::OFF_FRAME_LOSS_IRQ_EN:  rdMux = flIe_reg;
            ilb_pkg::OFF_FRAME_LOSS_LATCHED: rdMux = flLatched;
            ilb_pkg::OFF_GLOBAL_IRQ_STATUS:  rdMux = {6'h00, globalIrq_reg, 1'b0};
            default:                         rdMux = 8'h00;
        endcase
    end

    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= regRdStb ? rdMux : 8'h00;
        end
    end

    assign regRdData = rdData_reg;
endmodule // ilb_link_bonding_regs

// ===== core/ilb_pkg.sv
// ilb_pkg: constants shared by the link bonding status and control block
package ilb_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFF_BOND_CONFIG        = 8'h16;
    localparam logic [7:0] OFF_BOND_COMMAND       = 8'h17;
    localparam logic [7:0] OFF_SYNC_LIVE          = 8'h18;
    localparam logic [7:0] OFF_SYNC_IRQ_EN        = 8'h19;
    localparam logic [7:0] OFF_SYNC_LATCHED       = 8'h1A;
    localparam logic [7:0] OFF_SKEW_MEASURE       = 8'h1B;
    localparam logic [7:0] OFF_SKEW_ERR_IRQ_EN    = 8'h1C;
    localparam logic [7:0] OFF_SKEW_ERR_LATCHED   = 8'h1D;
    localparam logic [7:0] OFF_FRAME_LOSS_IRQ_EN  = 8'h1E;
    localparam logic [7:0] OFF_FRAME_LOSS_LATCHED = 8'h1F;
    localparam logic [7:0] OFF_GLOBAL_IRQ_STATUS  = 8'h0D;

    // command codes
    localparam logic [7:0] CMD_LINK_START = 8'h82;
    localparam logic [7:0] CMD_NOP        = 8'hFF;
    localparam logic [7:0] CMD_RESET      = 8'hFF;

    // reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;

    // field positions
    localparam int FLD_SKEW_ERR     = 0;
    localparam int FLD_GLOBAL_IRQ   = 1;
    localparam int FLD_SEND_ENABLE  = 4;
    localparam int FLD_PART_LSB     = 0;
    localparam int FLD_FAR_LSB      = 4;

    // sequence search: consecutive sequence numbers needed
    localparam logic [1:0] SEQ_RUN_NEEDED = 2'h3;

    // differential delay scale: one measure count per 0.25 ms
    localparam real SKEW_LIMIT_MS   = 7.75;
    localparam real SKEW_MAX_MS     = 64.0;
    localparam real SKEW_LSB_MS     = 0.25;
    localparam logic [7:0] SKEW_LIMIT_CNT = 8'(int'(SKEW_LIMIT_MS / SKEW_LSB_MS));
endpackage

// ===== core/ilb_seq_search.sv
// ilb_seq_search: per-portion search for consecutive sequence numbers
`timescale 1ns/1ps
module ilb_seq_search (
    input  wire logic       sys_clk,   // system clock
    input  wire logic       rst_b,     // sync reset, active low
    input  wire logic       arm,       // start searching (peer or local link-start)
    input  wire logic       seqValid,  // sequence number strobe
    input  wire logic [7:0] seqNum,    // received sequence number
    input  wire logic       frameLoss, // receiver out of frame
    output logic            inSync     // portion synchronised
);
    typedef enum logic [2:0] {
        ILB_IDLE   = 3'b001,
        ILB_SEARCH = 3'b010,
        ILB_SYNC   = 3'b100
    } ilb_search_e;

    ilb_search_e state_reg;
    ilb_search_e state_next;
    logic [1:0]  run_reg;
    logic [1:0]  run_next;
    logic [7:0]  last_reg;
    logic        follows;

    // a number follows if it is one past the last one seen
    assign follows = (seqNum == 8'(last_reg + 8'h01));

    // walk the run counter; any gap restarts the run at one
    always_comb begin
        state_next = state_reg;
        run_next   = run_reg;
        unique case (state_reg)
            ILB_IDLE: begin
                run_next = 2'h0;
                if (arm) begin
                    state_next = ILB_SEARCH;
                end
            end
            ILB_SEARCH: begin
                if (seqValid) begin
                    run_next = (follows && run_reg != 2'h0) ? 2'(run_reg + 2'h1) : 2'h1;
                    if (follows && run_reg == 2'(ilb_pkg::SEQ_RUN_NEEDED - 2'h1)) begin
                        state_next = ILB_SYNC; // see R2
                    end
                end
            end
            ILB_SYNC: begin
                if (frameLoss) begin
                    state_next = ILB_IDLE;
                end
            end
            default: begin
                state_next = ILB_IDLE;
            end
        endcase
        if (arm && state_reg != ILB_SEARCH) begin
            state_next = ILB_SEARCH;
            run_next   = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= ILB_IDLE;
            run_reg   <= 2'h0;
            last_reg  <= 8'h00;
        end else begin
            state_reg <= state_next;
            run_reg   <= run_next;
            if (seqValid) begin
                last_reg <= seqNum;
            end
        end
    end

    assign inSync = (state_reg == ILB_SYNC);
endmodule // ilb_seq_search

// ===== core/ilb_sticky_bits.sv
// ilb_sticky_bits: eight latched status bits with set-over-clear
`timescale 1ns/1ps
module ilb_sticky_bits (
    input  wire logic       sys_clk,  // system clock
    input  wire logic       rst_b,    // sync reset, active low
    input  wire logic [7:0] setEvent, // one bit per source event
    input  wire logic [7:0] clrMask,  // software clear, per bit
    output logic      [7:0] latched   // latched status
);
    logic [7:0] latched_reg;
    logic [7:0] latched_next;

    // set wins over clear so a coincident event is never lost
    assign latched_next = (latched_reg & ~clrMask) | setEvent; // see R18

    // reset to zero so nothing is pending after reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            latched_reg <= ilb_pkg::RST_ZERO; // see R19
        end else begin
            latched_reg <= latched_next;
        end
    end

    assign latched = latched_reg;
endmodule // ilb_sticky_bits

// ===== test/ilb_link_bonding_assertions.sv
// ilb_link_bonding_assertions: port-level checks of the bonding registers
`timescale 1ns/1ps
module ilb_link_bonding_assertions (
    input wire logic       sys_clk,         // clock
    input wire logic       rst_b,           // sync reset
    input wire logic [7:0] regAddr,         // offset
    input wire logic [7:0] regWrData,       // write data
    input wire logic       regWrStb,        // write strobe
    input wire logic       regRdStb,        // read strobe
    input wire logic [7:0] regRdData,       // read data
    input wire logic       linkStartTx,     // start pulse
    input wire logic [3:0] farFrameLoss,    // far loss
    input wire logic [3:0] localFrameLoss,  // local loss
    input wire logic [7:0] skewMeasure,     // delay
    input wire logic [3:0] linkParticipate, // links
    input wire logic       sendEnable,      // send
    input wire logic [3:0] linkTxEnable,    // gates
    input wire logic       bondGlobalIrq    // global
);
    // ----------------------------------------
    // decodes and helper state
    // ----------------------------------------
    wire logic       startWr = regWrStb && regAddr == ilb_pkg::OFF_BOND_COMMAND
                               && regWrData == ilb_pkg::CMD_LINK_START;
    wire logic       cfgWr   = regWrStb && regAddr == ilb_pkg::OFF_BOND_CONFIG;
    wire logic       enWr    = regWrStb && regWrData != 8'h00 && (regAddr == ilb_pkg::OFF_SYNC_IRQ_EN
                               || regAddr == ilb_pkg::OFF_SKEW_ERR_IRQ_EN || regAddr == ilb_pkg::OFF_FRAME_LOSS_IRQ_EN);
    wire logic [7:0] lossAll = {farFrameLoss, localFrameLoss};
    logic            enSeen_reg;

    // no irq is possible before software has written some enable
    always_ff @(posedge sys_clk) begin
        if (!rst_b) enSeen_reg <= 1'b0;
        else if (enWr) enSeen_reg <= 1'b1;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_start_pulse: assert property (startWr |=> linkStartTx)
        else $error("link start pulse missing");
    a_start_only_cmd: assert property (linkStartTx |-> $past(startWr))
        else $error("link start pulse without start code");
    a_read_idle: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data outside read cycle");
    a_config_write: assert property (
        cfgWr |=> {3'h0, sendEnable, linkParticipate} == ($past(regWrData) & 8'h1F))
        else $error("config outputs differ from write");
    a_tx_gate: assert property (
        $stable(linkParticipate) && $stable(sendEnable) |-> linkTxEnable == (linkParticipate & {4{sendEnable}}))
        else $error("link gate differs from config");
    a_skew_read: assert property (
        regRdStb && regAddr == ilb_pkg::OFF_SKEW_MEASURE && $stable(skewMeasure) |=> regRdData == $past(skewMeasure))
        else $error("skew readback wrong");
    a_skew_latch: assert property (
        regRdStb && regAddr == ilb_pkg::OFF_SKEW_ERR_LATCHED && $past(skewMeasure, 2) > ilb_pkg::SKEW_LIMIT_CNT
        |=> regRdData[0])
        else $error("skew error not latched");
    a_frame_latch: assert property (
        regRdStb && regAddr == ilb_pkg::OFF_FRAME_LOSS_LATCHED |=> (regRdData & $past(lossAll, 2)) == $past(lossAll, 2))
        else $error("frame loss not latched");
    a_global_read: assert property (
        regRdStb && regAddr == ilb_pkg::OFF_GLOBAL_IRQ_STATUS |=> regRdData[1] == $past(bondGlobalIrq))
        else $error("global status readback wrong");
    a_irq_needs_en: assert property (!enSeen_reg |-> !bondGlobalIrq)
        else $error("irq without any enable");

    c_link_start: cover property (linkStartTx);
    c_global_irq: cover property ($rose(bondGlobalIrq));
    c_loss_seen: cover property (|lossAll);
endmodule // ilb_link_bonding_assertions

bind ilb_link_bonding_regs ilb_link_bonding_assertions u_ilb_link_bonding_assertions (.sys_clk, .rst_b, .regAddr,
    .regWrData, .regWrStb, .regRdStb, .regRdData, .linkStartTx, .farFrameLoss, .localFrameLoss, .skewMeasure,
    .linkParticipate, .sendEnable, .linkTxEnable, .bondGlobalIrq);

// ===== test/ilb_link_bonding_regs_tb.sv
// ilb_link_bonding_regs_tb: self-checking bench for the bonding registers
`timescale 1ns/1ps
module ilb_link_bonding_regs_tb;
    typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] expVal;} ilb_row_s;
    logic        sys_clk = 1'b0, rst_b = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0, breakRun = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, skewMeasure = 8'h00, regRdData;
    logic [3:0]  farFrameLoss = 4'h0, localFrameLoss = 4'h0, peerRxSync, seqValid, linkParticipate, linkTxEnable;
    logic [31:0] seqNum;
    logic        linkStartTx, peerLinkStart, sendEnable, bondGlobalIrq;
    int          errTotal = 0, numChecks = 0, cycles = 0;
    ilb_row_s    rows [11] = '{
        '{8'h16, 8'h1F, 8'h1F}, '{8'h17, 8'h55, 8'hFF}, '{8'h17, 8'hFF, 8'hFF}, '{8'h18, 8'hFF, 8'h00},
        '{8'h19, 8'hA5, 8'hA5}, '{8'h1B, 8'hFF, 8'h00}, '{8'h1C, 8'h01, 8'h01}, '{8'h1E, 8'h5A, 8'h5A},
        '{8'h1A, 8'hFF, 8'h00}, '{8'h1D, 8'hFF, 8'h00}, '{8'h40, 8'h77, 8'h00}};

    ilb_link_bonding_regs u_ilb_link_bonding_regs (.sys_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb,
        .regRdData, .linkStartTx, .peerLinkStart, .peerRxSync, .farFrameLoss, .localFrameLoss, .seqValid, .seqNum,
        .skewMeasure, .linkParticipate, .sendEnable, .linkTxEnable, .bondGlobalIrq);
    ilb_peer_model u_ilb_peer_model (.sys_clk, .rst_b, .linkStartTx, .breakRun, .peerLinkStart, .peerRxSync,
        .seqValid, .seqNum);

    // ----------------------------------------
    // clock, watchdog and bus tasks
    // ----------------------------------------
    always #2 sys_clk = ~sys_clk;

    // the whole run needs under two hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errTotal++;
            tallyAndFinish();
        end
    end

    task automatic chk(input string what, input logic [7:0] expVal, input logic [7:0] seen);
        numChecks++;
        if (seen !== expVal) begin
            $display("mismatch %s expected %h seen %h", what, expVal, seen);
            errTotal++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge sys_clk);
        regWrStb  <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, regRdData);
    endtask

    task automatic tallyAndFinish();
        if (errTotal == 0 && numChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        idle(3);
        rst_b <= 1'b1;
        idle(2);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].expVal);
        end
        // link start and a clean run of numbers from the peer
        wr(ilb_pkg::OFF_BOND_COMMAND, ilb_pkg::CMD_LINK_START);
        #1 chk("linkStartTx", 8'h01, {7'h0, linkStartTx});
        idle(20);
        rd(8'h18, 8'hFF);
        rd(8'h1A, 8'hFF);
        rd(8'h17, 8'h82);
        wr(8'h17, 8'hFF);
        rd(8'h17, 8'hFF);
        chk("bondGlobalIrq", 8'h01, {7'h0, bondGlobalIrq});
        rd(8'h0D, 8'h02);
        wr(8'h19, 8'h00);
        idle(2);
        #1 chk("bondGlobalIrq", 8'h00, {7'h0, bondGlobalIrq});
        // one-cycle frame loss on far link 4 and local link 2
        @(posedge sys_clk);
        farFrameLoss   <= 4'h8;
        localFrameLoss <= 4'h2;
        @(posedge sys_clk);
        farFrameLoss   <= 4'h0;
        localFrameLoss <= 4'h0;
        idle(2);
        rd(8'h1F, 8'h82);
        rd(8'h18, 8'hFD);
        chk("bondGlobalIrq", 8'h01, {7'h0, bondGlobalIrq});
        wr(8'h1E, 8'h40);
        idle(2);
        #1 chk("bondGlobalIrq", 8'h00, {7'h0, bondGlobalIrq});
        wr(8'h1F, 8'h82);
        rd(8'h1F, 8'h00);
        wr(8'h16, 8'h0F);
        idle(1);
        #1 chk("linkTxEnable", 8'h00, {4'h0, linkTxEnable});
        wr(8'h16, 8'h15);
        idle(1);
        #1 chk("linkTxEnable", 8'h05, {4'h0, linkTxEnable});
        // skew exactly at the limit, then one sample above it
        @(posedge sys_clk);
        skewMeasure <= 8'h1F;
        idle(3);
        rd(8'h1D, 8'h00);
        rd(8'h1B, 8'h1F);
        @(posedge sys_clk);
        skewMeasure <= 8'h20;
        @(posedge sys_clk);
        skewMeasure <= 8'h00;
        idle(3);
        rd(8'h1D, 8'h01);
        chk("bondGlobalIrq", 8'h01, {7'h0, bondGlobalIrq});
        wr(8'h1D, 8'h01);
        rd(8'h1D, 8'h00);
        // second reset in mid-run
        @(posedge sys_clk);
        rst_b <= 1'b0;
        idle(3);
        rst_b <= 1'b1;
        idle(2);
        breakRun <= 1'b1;
        for (int a = 8'h16; a <= 8'h1F; a++) rd(8'(a), (a == 8'h17) ? 8'hFF : 8'h00);
        // peer sends a run with a gap: local search must not lock
        wr(8'h16, 8'h0F);
        wr(ilb_pkg::OFF_BOND_COMMAND, ilb_pkg::CMD_LINK_START);
        idle(20);
        rd(8'h18, 8'hF0);
        tallyAndFinish();
    end
endmodule // ilb_link_bonding_regs_tb

// ===== test/ilb_peer_model.sv
// ilb_peer_model: far-end bonding peer answering a link start
`timescale 1ns/1ps
module ilb_peer_model (
    input  wire logic        sys_clk,       // clock
    input  wire logic        rst_b,         // sync reset
    input  wire logic        linkStartTx,   // start from device
    input  wire logic        breakRun,      // send a broken number run
    output logic             peerLinkStart, // start pulse to device
    output logic      [3:0]  peerRxSync,    // far receive sync
    output logic      [3:0]  seqValid,      // number strobe
    output logic      [31:0] seqNum         // numbers, all portions
);
    // ----------------------------------------
    // handshake sequencer
    // ----------------------------------------
    int         step = 0;
    logic [7:0] num;

    // broken run skips one number, leaving only two in a row
    assign num = 8'h3B + 8'(step) + {7'h0, breakRun && step > 5};

    initial {peerLinkStart, peerRxSync, seqValid, seqNum} = '0;

    // gap after the start pulse lets the device arm before numbers come
    always @(posedge sys_clk) begin
        peerLinkStart <= 1'b0;
        seqValid      <= 4'h0;
        seqNum        <= ~seqNum; // idle lines keep toggling
        if (!rst_b) begin
            step       <= 0;
            peerRxSync <= 4'h0;
        end else if (linkStartTx) begin
            step <= 1;
        end else if (step != 0) begin
            step <= (step == 8) ? 0 : step + 1;
            if (step == 3) peerLinkStart <= 1'b1;
            if (step >= 5 && step <= 7) begin
                seqValid <= 4'hF;
                seqNum   <= {4{num}};
            end
            if (step == 8) peerRxSync <= 4'hF;
        end
    end
endmodule // ilb_peer_model
